// [pkg/adcseq_conv_if.sv]
`default_nettype none
// Request and result path between sequencer and converter handshake
interface adcseq_conv_if;
  logic start;
  logic [4:0] chan;
  logic busy;
  logic done;
  logic [11:0] data;
  modport seq (output start, output chan, input busy, input done, input data);
  modport cnv (input start, input chan, output busy, output done, output data);
endinterface
`default_nettype wire

// [pkg/adcseq_params.svh]
`ifndef ADCSEQ_PARAMS_SVH
`define ADCSEQ_PARAMS_SVH
// Register byte offsets
`define ADCSEQ_OFF_CTRL 12'h000
`define ADCSEQ_OFF_STAT 12'h004
`define ADCSEQ_OFF_MASK 12'h008
`define ADCSEQ_OFF_SCAN 12'h00c
`define ADCSEQ_OFF_CHAN 12'h010
`define ADCSEQ_OFF_WDOG 12'h014
`define ADCSEQ_OFF_WSEL 12'h018
`define ADCSEQ_OFF_RDAT 12'h01c
`define ADCSEQ_OFF_JDAT 12'h020
`define ADCSEQ_OFF_CALT 12'h024
`define ADCSEQ_OFF_CALR 12'h028
// Control fields
`define ADCSEQ_CTRL_EN 0
`define ADCSEQ_CTRL_SCAN 1
`define ADCSEQ_CTRL_START 2
`define ADCSEQ_CTRL_TRGEN 3
`define ADCSEQ_CTRL_JTRGEN 4
`define ADCSEQ_CTRL_JSTART 5
`define ADCSEQ_CTRL_DMAEN 6
`define ADCSEQ_CTRL_AUTOOFF 7
`define ADCSEQ_CTRL_WDEN 8
`define ADCSEQ_CTRL_WMODE_LO 9
// Status fields
`define ADCSEQ_ST_EOC 0
`define ADCSEQ_ST_JEOC 1
`define ADCSEQ_ST_AWD 2
`define ADCSEQ_ST_OVR 3
// Channel numbers and widths
`define ADCSEQ_NCH 26
`define ADCSEQ_CH_TEMP 5'd16
`define ADCSEQ_CH_VREF 5'd17
`define ADCSEQ_RES_W 12
// Timing
`define ADCSEQ_T_WAKE_NS 1000
`define ADCSEQ_WAKE_CYC ((`ADCSEQ_T_WAKE_NS + 99) / 100)
// Factory calibration reset values (arbitrary)
`define ADCSEQ_CAL_TEMP 32'h0000_0a5a
`define ADCSEQ_CAL_VREF 32'h0000_05a5
`endif

// [pkg/adcseq_pkg.sv]
`default_nettype none
package adcseq_pkg;
  typedef enum logic [1:0] {AQ_OFF, AQ_WAKE, AQ_IDLE, AQ_CONV} adcseq_state_t;
  typedef enum logic [1:0] {AQ_WD_ONE, AQ_WD_SET, AQ_WD_ALL} adcseq_wdmode_t;
endpackage
`default_nettype wire

// [rtl/adcseq_conv.sv]
`include "adcseq_params.svh"
`default_nettype none
// Hands one conversion to the analog macro and returns its result
module adcseq_conv
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sequencer side
  adcseq_conv_if.cnv cif,
  // Analog macro side
  output logic ana_start,
  output logic [4:0] ana_chan,
  input wire logic ana_eoc,
  input wire logic [11:0] ana_data
);
  logic busy_reg;
  logic done_reg;
  logic [11:0] data_reg;
  logic [4:0] chan_reg;

  // Conversion tracking
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      busy_reg <= 1'b0;
    else if (cif.start)
      busy_reg <= 1'b1;
    else if (ana_eoc)
      busy_reg <= 1'b0;
  end

  // Channel latch
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      chan_reg <= 5'h00;
    else if (cif.start)
      chan_reg <= cif.chan;
  end

  // Result capture
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      done_reg <= 1'b0;
      data_reg <= 12'h000;
    end
    else
    begin
      done_reg <= busy_reg && ana_eoc;
      if (busy_reg && ana_eoc)
        data_reg <= ana_data;
    end
  end

  assign ana_start = cif.start;
  assign ana_chan = cif.start ? cif.chan : chan_reg;
  assign cif.busy = busy_reg;
  assign cif.done = done_reg;
  assign cif.data = data_reg;
endmodule
`default_nettype wire

// [rtl/adcseq_top.sv]
// Functional notes
// - 12-bit results, 26 channels, single and scan
// - scan steps through selected channel group
// - DMA request per regular result, cleared when read
// - watchdog guards one, some or all channels
// - interrupt when guarded result leaves window
// - timer events start regular and injected conversions
// - injection suspends scan, then scan resumes
// - conversion clock independent of processor clock (the converter handshake here runs on the system clock CLK)
// - optional auto power-down between conversions
// - channel 16 is the temperature sensor
// - channel 17 is the bandgap reference
// - calibration values read-only, writes rejected
//
// Decided for this implementation: the APB register port and the register offsets.
`include "adcseq_params.svh"
`default_nettype none
module adcseq_top
  import adcseq_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Timer trigger events
  input wire logic TIMER_TRIG,
  input wire logic TIMER_JTRIG,
  // DMA handshake
  output logic DMA_REQ,
  // Analog macro
  output logic ANA_POWER,
  output logic ANA_START,
  output logic [4:0] ANA_CHAN,
  input wire logic ANA_EOC,
  input wire logic [11:0] ANA_DATA,
  // Interrupt
  output logic IRQ
);
  adcseq_conv_if cif();
  adcseq_state_t state_reg;
  logic [10:0] ctrl_reg;
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  logic [`ADCSEQ_NCH-1:0] scan_reg;
  logic [`ADCSEQ_NCH-1:0] wsel_reg;
  logic [4:0] chan_reg;
  logic [4:0] jchan_reg;
  logic [4:0] wchan_reg;
  logic [23:0] wdog_reg;
  logic [11:0] rdat_reg;
  logic [11:0] jdat_reg;
  logic [4:0] pos_reg;
  logic [4:0] cur_chan_reg;
  logic cur_inj_reg;
  logic reg_pend_reg;
  logic inj_pend_reg;
  logic dma_reg;
  logic [3:0] wake_reg;
  logic wr_en;
  logic rd_en;
  logic awd_hit;
  logic [3:0] stat_set;
  logic [4:0] next_pos;
  logic scan_last;

  // Finds the next selected channel at or after a position
  function automatic logic [4:0] adcseq_next(input logic [`ADCSEQ_NCH-1:0] set,
                                             input logic [4:0] from);
    logic [4:0] r;
    logic hit;
    r = from;
    hit = 1'b0;
    for (int i = 0; i < `ADCSEQ_NCH; i++)
    begin
      if (!hit && i >= from && set[i])
      begin
        r = 5'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // Address match helper
  function automatic logic adcseq_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Bus strobes, zero wait state
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;

  // Converter handshake, runs on the system clock alone
  adcseq_conv u_conv
  (
    .clk(CLK),
    .reset(RESET),
    .cif(cif.cnv),
    .ana_start(ANA_START),
    .ana_chan(ANA_CHAN),
    .ana_eoc(ANA_EOC),
    .ana_data(ANA_DATA)
  );

  // Window comparator
  adcseq_wdog u_wdog
  (
    .enable(ctrl_reg[`ADCSEQ_CTRL_WDEN]),
    .mode(adcseq_wdmode_t'(ctrl_reg[`ADCSEQ_CTRL_WMODE_LO +: 2])),
    .watch_chan(wchan_reg),
    .watch_set(wsel_reg),
    .chan(cur_chan_reg),
    .data(cif.data),
    .low(wdog_reg[11:0]),
    .high(wdog_reg[23:12]),
    .out_of_window(awd_hit)
  );

  // Control register; start bits self-clear
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ctrl_reg <= 11'h000;
    else if (wr_en && adcseq_hit(PADDR, `ADCSEQ_OFF_CTRL))
      ctrl_reg <= PWDATA[10:0];
    else
    begin
      ctrl_reg[`ADCSEQ_CTRL_START] <= 1'b0;
      ctrl_reg[`ADCSEQ_CTRL_JSTART] <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      mask_reg <= 4'h0;
      scan_reg <= '0;
      chan_reg <= 5'h00;
      jchan_reg <= 5'h00;
      wchan_reg <= 5'h00;
      wdog_reg <= 24'hfff000;
      wsel_reg <= '0;
    end
    else if (wr_en)
    begin
      if (adcseq_hit(PADDR, `ADCSEQ_OFF_MASK))
        mask_reg <= PWDATA[3:0];
      if (adcseq_hit(PADDR, `ADCSEQ_OFF_SCAN))
        scan_reg <= PWDATA[`ADCSEQ_NCH-1:0];
      if (adcseq_hit(PADDR, `ADCSEQ_OFF_CHAN))
      begin
        chan_reg <= PWDATA[4:0];
        jchan_reg <= PWDATA[12:8];
        wchan_reg <= PWDATA[20:16];
      end
      if (adcseq_hit(PADDR, `ADCSEQ_OFF_WDOG))
        wdog_reg <= PWDATA[23:0];
      if (adcseq_hit(PADDR, `ADCSEQ_OFF_WSEL))
        wsel_reg <= PWDATA[`ADCSEQ_NCH-1:0];
    end
  end

  // Pending regular and injected requests
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      reg_pend_reg <= 1'b0;
      inj_pend_reg <= 1'b0;
    end
    else if (!ctrl_reg[`ADCSEQ_CTRL_EN])
    begin
      reg_pend_reg <= 1'b0;
      inj_pend_reg <= 1'b0;
    end
    else
    begin
      if (ctrl_reg[`ADCSEQ_CTRL_START] || (ctrl_reg[`ADCSEQ_CTRL_TRGEN] && TIMER_TRIG))
        reg_pend_reg <= 1'b1;
      else if (state_reg == AQ_IDLE && !inj_pend_reg)
        reg_pend_reg <= 1'b0;
      if (ctrl_reg[`ADCSEQ_CTRL_JSTART] || (ctrl_reg[`ADCSEQ_CTRL_JTRGEN] && TIMER_JTRIG))
        inj_pend_reg <= 1'b1;
      else if (state_reg == AQ_IDLE)
        inj_pend_reg <= 1'b0;
    end
  end

  assign next_pos = adcseq_next(scan_reg, 5'(cur_chan_reg + 5'd1));
  assign scan_last = !ctrl_reg[`ADCSEQ_CTRL_SCAN] || cur_chan_reg == 5'(`ADCSEQ_NCH - 1)
                     || next_pos <= cur_chan_reg || !scan_reg[next_pos];

  // Sequencer; scan position survives an injection
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_reg <= AQ_OFF;
      pos_reg <= 5'h00;
      cur_chan_reg <= 5'h00;
      cur_inj_reg <= 1'b0;
      wake_reg <= 4'h0;
    end
    else if (!ctrl_reg[`ADCSEQ_CTRL_EN])
    begin
      state_reg <= AQ_OFF;
      pos_reg <= 5'h00;
    end
    else
    begin
      unique case (state_reg)
        AQ_OFF:
        begin
          wake_reg <= 4'(`ADCSEQ_WAKE_CYC);
          if (!ctrl_reg[`ADCSEQ_CTRL_AUTOOFF] || reg_pend_reg || inj_pend_reg)
            state_reg <= AQ_WAKE;
        end
        AQ_WAKE:
        begin
          if (wake_reg <= 4'h1)
            state_reg <= AQ_IDLE;
          wake_reg <= wake_reg - 4'h1;
        end
        AQ_IDLE:
        begin
          if (inj_pend_reg)
          begin
            cur_chan_reg <= jchan_reg;
            cur_inj_reg <= 1'b1;
            state_reg <= AQ_CONV;
          end
          else if (reg_pend_reg || pos_reg != 5'h00)
          begin
            cur_chan_reg <= ctrl_reg[`ADCSEQ_CTRL_SCAN] ? adcseq_next(scan_reg, pos_reg)
                                                        : chan_reg;
            cur_inj_reg <= 1'b0;
            state_reg <= AQ_CONV;
          end
          else if (ctrl_reg[`ADCSEQ_CTRL_AUTOOFF])
            state_reg <= AQ_OFF;
        end
        AQ_CONV:
        begin
          if (cif.done)
          begin
            state_reg <= AQ_IDLE;
            if (!cur_inj_reg)
              pos_reg <= (scan_last) ? 5'h00 : next_pos;
          end
        end
      endcase
    end
  end

  // Channel 16 and 17 are the sensor and reference inputs of the macro
  assign cif.chan = cur_chan_reg;
  assign cif.start = state_reg == AQ_CONV && !cif.busy && !cif.done;
  assign ANA_POWER = state_reg != AQ_OFF;

  // Result registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rdat_reg <= 12'h000;
      jdat_reg <= 12'h000;
    end
    else if (cif.done && state_reg == AQ_CONV)
    begin
      if (cur_inj_reg)
        jdat_reg <= cif.data;
      else
        rdat_reg <= cif.data;
    end
  end

  // Event bits: set wins over read clear
  always_comb
  begin
    stat_set = 4'h0;
    if (cif.done && state_reg == AQ_CONV)
    begin
      stat_set[`ADCSEQ_ST_EOC] = !cur_inj_reg;
      stat_set[`ADCSEQ_ST_JEOC] = cur_inj_reg;
      stat_set[`ADCSEQ_ST_AWD] = awd_hit;
      stat_set[`ADCSEQ_ST_OVR] = !cur_inj_reg && dma_reg;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      stat_reg <= 4'h0;
    else if (rd_en && adcseq_hit(PADDR, `ADCSEQ_OFF_STAT))
      stat_reg <= stat_set;
    else
      stat_reg <= stat_reg | stat_set;
  end

  // DMA request per regular result, dropped by the result read
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      dma_reg <= 1'b0;
    else if (stat_set[`ADCSEQ_ST_EOC] && ctrl_reg[`ADCSEQ_CTRL_DMAEN])
      dma_reg <= 1'b1;
    else if (rd_en && adcseq_hit(PADDR, `ADCSEQ_OFF_RDAT))
      dma_reg <= 1'b0;
  end

  assign DMA_REQ = dma_reg;
  assign IRQ = |(stat_reg & mask_reg);

  // Read mux; calibration words are constants
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    PSLVERR = 1'b0;
    unique case (PADDR)
      `ADCSEQ_OFF_CTRL: PRDATA = {21'h0, ctrl_reg};
      `ADCSEQ_OFF_STAT: PRDATA = {28'h0, stat_reg};
      `ADCSEQ_OFF_MASK: PRDATA = {28'h0, mask_reg};
      `ADCSEQ_OFF_SCAN: PRDATA = {6'h0, scan_reg};
      `ADCSEQ_OFF_CHAN: PRDATA = {11'h0, wchan_reg, 3'h0, jchan_reg, 3'h0, chan_reg};
      `ADCSEQ_OFF_WDOG: PRDATA = {8'h0, wdog_reg};
      `ADCSEQ_OFF_WSEL: PRDATA = {6'h0, wsel_reg};
      `ADCSEQ_OFF_RDAT: PRDATA = {20'h0, rdat_reg};
      `ADCSEQ_OFF_JDAT: PRDATA = {20'h0, jdat_reg};
      `ADCSEQ_OFF_CALT:
      begin
        PRDATA = `ADCSEQ_CAL_TEMP;
        PSLVERR = PSEL && PENABLE && PWRITE;
      end
      `ADCSEQ_OFF_CALR:
      begin
        PRDATA = `ADCSEQ_CAL_VREF;
        PSLVERR = PSEL && PENABLE && PWRITE;
      end
      default: PSLVERR = PSEL && PENABLE;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/adcseq_wdog.sv]
`include "adcseq_params.svh"
`default_nettype none
// Window comparison of a result against programmed thresholds
module adcseq_wdog
  import adcseq_pkg::*;
(
  input wire logic enable,
  input wire adcseq_wdmode_t mode,
  input wire logic [4:0] watch_chan,
  input wire logic [`ADCSEQ_NCH-1:0] watch_set,
  input wire logic [4:0] chan,
  input wire logic [11:0] data,
  input wire logic [11:0] low,
  input wire logic [11:0] high,
  output logic out_of_window
);
  logic guarded;

  // Channel selection for guarding
  always_comb
  begin
    guarded = 1'b0;
    unique case (mode)
      AQ_WD_ONE: guarded = (chan == watch_chan);
      AQ_WD_SET: guarded = watch_set[chan];
      AQ_WD_ALL: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  end

  assign out_of_window = enable && guarded && ((data < low) || (data > high));
endmodule
`default_nettype wire

// [testbench/adc_conversion_sequencer_bench.sv]
`include "adcseq_params.svh"
`default_nettype none
module adc_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
  logic TIMER_TRIG = 0, TIMER_JTRIG = 0, PREADY, PSLVERR, DMA_REQ, IRQ;
  logic ANA_POWER, ANA_START, ANA_EOC, e;
  logic [11:0] PADDR = 12'h000, ANA_DATA;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic [4:0] ANA_CHAN;
  logic [4:0] chq [$];
  int fail_count = 0, cmp_count = 0, cyc_count = 0;
  // Rows: write, address, data, expected read, expected error
  logic [77:0] rows [10] = '{
    {1'b0, `ADCSEQ_OFF_WDOG, 32'h0, 32'h00fff000, 1'b0},
    {1'b0, `ADCSEQ_OFF_CALT, 32'h0, `ADCSEQ_CAL_TEMP, 1'b0},
    {1'b1, `ADCSEQ_OFF_CALT, 32'hffffffff, 32'h0, 1'b1},
    {1'b0, `ADCSEQ_OFF_CALT, 32'h0, `ADCSEQ_CAL_TEMP, 1'b0},
    {1'b0, `ADCSEQ_OFF_CALR, 32'h0, `ADCSEQ_CAL_VREF, 1'b0},
    {1'b1, `ADCSEQ_OFF_CALR, 32'h0, 32'h0, 1'b1},
    {1'b0, `ADCSEQ_OFF_CALR, 32'h0, `ADCSEQ_CAL_VREF, 1'b0},
    {1'b0, 12'h100, 32'h0, 32'h0, 1'b1},
    {1'b1, `ADCSEQ_OFF_MASK, 32'h0000000f, 32'h0, 1'b0},
    {1'b0, `ADCSEQ_OFF_MASK, 32'h0, 32'h0000000f, 1'b0}};

  adcseq_top i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TIMER_TRIG(TIMER_TRIG), .TIMER_JTRIG(TIMER_JTRIG),
    .DMA_REQ(DMA_REQ), .ANA_POWER(ANA_POWER), .ANA_START(ANA_START),
    .ANA_CHAN(ANA_CHAN), .ANA_EOC(ANA_EOC), .ANA_DATA(ANA_DATA), .IRQ(IRQ));
  adcseq_ana_model i_ana (.clk(CLK), .reset(RESET), .slow(slow), .start(ANA_START),
    .chan(ANA_CHAN), .eoc(ANA_EOC), .data(ANA_DATA));

  // 10 MHz clock
  always #50 CLK = ~CLK;
  // Channel log and hang guard
  always @(posedge CLK)
  begin
    if (ANA_START === 1'b1) chq.push_back(ANA_CHAN);
    cyc_count++;
    if (cyc_count == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // One bus transfer, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK iff PREADY === 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task pulse_trig(input logic inj);
    if (inj) TIMER_JTRIG <= 1'b1;
    else TIMER_TRIG <= 1'b1;
    @(posedge CLK);
    TIMER_JTRIG <= 1'b0;
    TIMER_TRIG <= 1'b0;
  endtask

  initial
  begin
    cyc(16);
    chk(IRQ, 0);
    chk(ANA_POWER, 0);
    RESET <= 1'b0;
    @(posedge CLK);
    foreach (rows[i])
    begin
      apb(rows[i][77], rows[i][76:65], rows[i][64:33]);
      if (!rows[i][77]) chk(r, rows[i][32:1]);
      chk(e, rows[i][0]);
    end
    // Temperature channel, single shot with transfer request
    apb(1'b1, `ADCSEQ_OFF_CHAN, 32'h10);
    apb(1'b1, `ADCSEQ_OFF_MASK, 32'h1);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h41);
    cyc(12);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h45);
    @(posedge CLK iff ANA_START === 1'b1);
    chk(ANA_CHAN, 16);
    @(posedge CLK iff DMA_REQ === 1'b1);
    chk(IRQ, 1);
    rd(`ADCSEQ_OFF_RDAT, 32'h400);
    chk(DMA_REQ, 0);
    rd(`ADCSEQ_OFF_STAT, 32'h1);
    chk(IRQ, 0);
    // Reference channel from a timer event
    apb(1'b1, `ADCSEQ_OFF_CHAN, 32'h11);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h09);
    pulse_trig(1'b0);
    @(posedge CLK iff ANA_START === 1'b1);
    chk(ANA_CHAN, 17);
    @(posedge CLK iff IRQ === 1'b1);
    rd(`ADCSEQ_OFF_RDAT, 32'h440);
    rd(`ADCSEQ_OFF_STAT, 32'h1);
    // Scan of channels 1 and 3 with injected channel 5 in between
    slow <= 1'b1;
    chq.delete();
    apb(1'b1, `ADCSEQ_OFF_SCAN, 32'h0a);
    apb(1'b1, `ADCSEQ_OFF_CHAN, 32'h500);
    apb(1'b1, `ADCSEQ_OFF_MASK, 32'h2);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h17);
    @(posedge CLK iff ANA_START === 1'b1);
    pulse_trig(1'b1);
    @(posedge CLK iff chq.size() == 3);
    cyc(20);
    chk(chq[0], 1);
    chk(chq[1], 5);
    chk(chq[2], 3);
    rd(`ADCSEQ_OFF_JDAT, 32'h140);
    rd(`ADCSEQ_OFF_STAT, 32'h3);
    // Watchdog on one channel, then on all, with power-down between
    slow <= 1'b0;
    apb(1'b1, `ADCSEQ_OFF_WDOG, 32'h200100);
    apb(1'b1, `ADCSEQ_OFF_CHAN, 32'h050010);
    apb(1'b1, `ADCSEQ_OFF_MASK, 32'h4);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h185);
    @(posedge CLK iff ANA_START === 1'b1);
    cyc(10);
    chk(ANA_POWER, 0);
    rd(`ADCSEQ_OFF_STAT, 32'h1);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h585);
    @(posedge CLK iff ANA_START === 1'b1);
    cyc(8);
    chk(IRQ, 1);
    rd(`ADCSEQ_OFF_STAT, 32'h5);
    // Watchdog on a channel subset, inside and then outside the set
    apb(1'b1, `ADCSEQ_OFF_WSEL, 32'h10000);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h385);
    @(posedge CLK iff ANA_START === 1'b1);
    cyc(8);
    rd(`ADCSEQ_OFF_STAT, 32'h5);
    apb(1'b1, `ADCSEQ_OFF_WSEL, 32'h20);
    apb(1'b1, `ADCSEQ_OFF_CTRL, 32'h385);
    @(posedge CLK iff ANA_START === 1'b1);
    cyc(8);
    chk(IRQ, 0);
    rd(`ADCSEQ_OFF_STAT, 32'h1);
    // Reset in mid-run
    RESET <= 1'b1;
    cyc(2);
    chk(ANA_POWER, 0);
    chk(IRQ, 0);
    RESET <= 1'b0;
    @(posedge CLK);
    rd(`ADCSEQ_OFF_WDOG, 32'h00fff000);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [testbench/adcseq_ana_model.sv]
`default_nettype none
// Behavioural analog converter macro
module adcseq_ana_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Speed select
  input wire logic slow,
  // Converter handshake
  input wire logic start,
  input wire logic [4:0] chan,
  output logic eoc,
  output logic [11:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [4:0] ch_reg;
  // Result is channel times 64; data toggles while not valid
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      cnt <= 0;
      eoc <= 1'b0;
      data <= 12'h000;
    end
    else
    begin
      eoc <= 1'b0;
      if (start)
      begin
        cnt <= slow ? 12 : 3;
        ch_reg <= chan;
      end
      else if (cnt == 1)
      begin
        cnt <= 0;
        eoc <= 1'b1;
        data <= {1'b0, ch_reg, 6'h00};
      end
      else
      begin
        if (cnt != 0) cnt <= cnt - 1;
        data <= ~data;
      end
    end
endmodule
`default_nettype wire

// [testbench/adcseq_props.sv]
`include "adcseq_params.svh"
`default_nettype none
// Port-level checks on the sequencer top
module adcseq_props
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // Converter and transfer request
  input wire logic DMA_REQ,
  input wire logic ANA_POWER,
  input wire logic ANA_START,
  input wire logic [4:0] ANA_CHAN,
  input wire logic ANA_EOC
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic acc;
  // Access phase of a bus transfer
  assign acc = PSEL && PENABLE;
  AST_CAL_WRITE: assert property (acc && PWRITE && (PADDR == `ADCSEQ_OFF_CALT ||
    PADDR == `ADCSEQ_OFF_CALR) |-> PSLVERR) else $error("calibration write accepted");
  AST_CAL_READ: assert property (acc && !PWRITE && PADDR == `ADCSEQ_OFF_CALT
    |-> !PSLVERR && PRDATA == `ADCSEQ_CAL_TEMP) else $error("calibration word changed");
  AST_START_PULSE: assert property (ANA_START |=> !ANA_START)
    else $error("start longer than one cycle");
  AST_START_POWERED: assert property (ANA_START |-> ANA_POWER)
    else $error("start while powered down");
  AST_WAKE: assert property ($rose(ANA_POWER) |-> !ANA_START [*8])
    else $error("start before wake time");
  AST_CHAN: assert property (ANA_START |-> ANA_CHAN < 5'd26)
    else $error("channel out of range");
  AST_DMA_CAUSE: assert property ($rose(DMA_REQ) |-> $past(ANA_EOC, 2))
    else $error("transfer request without result");
  AST_DMA_CLEAR: assert property (acc && !PWRITE && PADDR == `ADCSEQ_OFF_RDAT
    && !ANA_EOC && !$past(ANA_EOC) |=> !DMA_REQ) else $error("request kept after read");
endmodule
bind adcseq_top adcseq_props i_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .DMA_REQ(DMA_REQ), .ANA_POWER(ANA_POWER), .ANA_START(ANA_START), .ANA_CHAN(ANA_CHAN),
  .ANA_EOC(ANA_EOC));
`default_nettype wire
